/* File: rtl/halt_dbg_pkg.sv */
// constants and helpers shared by the halt mode debug entry block
package halt_dbg_pkg;

  // scan frame: op in the low bits, payload above
  localparam int          FRAME_BITS = 36;
  localparam int          OP_W       = 4;
  localparam logic [5:0]  FRAME_LEN  = 6'h24;
  localparam logic [3:0]  OP_POLL     = 4'h0;
  localparam logic [3:0]  OP_WR_CSR   = 4'h1;
  localparam logic [3:0]  OP_LINE     = 4'h2;
  localparam logic [3:0]  OP_WORD     = 4'h3;
  localparam logic [3:0]  OP_INV_ALL  = 4'h4;
  localparam logic [3:0]  OP_INV_LINE = 4'h5;

  // mini instruction cache geometry: 32 sets, 2 ways, 8 words (2 KB)
  localparam int          SETS      = 32;
  localparam int          WAYS      = 2;
  localparam int          WORDS     = 8;
  localparam int          LINES     = SETS * WAYS;
  localparam int          MEM_AW    = 9;
  localparam int          TAG_W     = 22;
  localparam int          SET_LSB   = 5;
  localparam int          TAG_LSB   = 10;
  localparam int          WORD_LSB  = 2;
  localparam logic [2:0]  LAST_WORD = 3'h7;

  // debug vectors, default and relocated
  localparam logic [31:0] VEC_LOW  = 32'h0000_0000;
  localparam logic [31:0] VEC_HIGH = 32'hffff_0000;

  // debug control/status register fields and reset value
  localparam int          CSR_GE_BIT   = 31;
  localparam int          CSR_TRAP_BIT = 16;
  localparam logic [31:0] CSR_RST      = 32'h0000_0000;

  // register port offsets
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_CLEAR  = 4'h4;
  localparam logic [3:0]  REG_ENABLE = 4'h8;
  localparam logic [3:0]  REG_CSR    = 4'hc;

  // event bits of status, clear and enable
  localparam int          EV_W      = 4;
  localparam int          EV_TX_WR  = 0;
  localparam int          EV_HOST_RD = 1;
  localparam int          EV_ENTRY  = 2;
  localparam int          EV_CLASH  = 3;
  localparam logic [3:0]  EV_RST    = 4'h0;

  typedef enum logic [1:0] {md_reset, md_run, md_debug} mode_e;

  function automatic logic [4:0] set_of(input logic [31:0] a);
    return a[SET_LSB+4:SET_LSB];
  endfunction : set_of

  function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
    return a[31:TAG_LSB];
  endfunction : tag_of

  function automatic logic [5:0] line_of(input logic [4:0] s, input logic w);
    return {s, w};
  endfunction : line_of

endpackage : halt_dbg_pkg

/* File: rtl/sync2.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 3
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = i_d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end

  assign o_q = s_r.s2;
endmodule : sync2

/* File: rtl/mini_icache_mem.sv */
// data array of the mini instruction cache, registered read
`timescale 1ns/1ps
module mini_icache_mem
  import halt_dbg_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_we,
  input  wire logic [MEM_AW-1:0] i_waddr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [MEM_AW-1:0] i_raddr,
  output logic      [31:0]       o_rdata
);
  // R13 two kilobyte array
  logic [31:0] mem [LINES*WORDS];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : mini_icache_mem

/* File: rtl/halt_mode_debug_entry.sv */
// halt mode debug entry: reset trap, debug vectors, tx handshake, mini icache
// Overview of operation
// R01 - debugger loads handler and override vector tables while core is in reset
// R02 - trap bit set during reset gives debug exception at reset release
// R03 - with global enable clear only the reset trap may raise an exception
// R04 - debugger sets global enable before handler leaves reset trap entry
// R05 - relocated vector table moves the debug vector to the high address
// R06 - vector tables fill set 0; downloads to low 12 bits zero flagged
// R07 - reset vector branch reach limits handler placement, host concern
// R08 - handler write to transmit register sets ready flag polled by host
// R09 - debug mode fetches skip translation; data accesses keep it
// R10 - no debug stack pointer; scratch register is temporary and lost
// R11 - handler avoids multi loads, pc loads, swaps and coprocessor transfers
// R12 - handler never enters user mode, uses system mode instead
// R13 - a separate 2 KB mini instruction cache holds handler and tables
// R14 - downloads go to the way the set's round-robin pointer selects
// R15 - application fetches never fill or replace mini cache lines
// R16 - handler keeps critical code out of dynamic download sets
// R17 - transmit register write sets bit 0 of the scan register
// R18 - 32 sets by 2 ways by 8 words, round-robin download replacement
// R19 - ready flag clears once host has read transmit data
`timescale 1ns/1ps
module halt_mode_debug_entry (
  input  wire logic                      i_clk,
  input  wire logic                      i_srst,
  input  wire logic                      i_tck,
  input  wire logic                      i_tsel,
  input  wire logic                      i_tdi,
  output logic                           o_tdo,
  input  wire logic                      i_core_in_reset,
  input  wire logic                      i_vec_relocated,
  input  wire logic                      i_dbg_event,
  input  wire logic                      i_handler_exit,
  output logic                           o_debug_exc,
  output logic [31:0]                    o_debug_vector,
  output logic                           o_debug_mode,
  output logic                           o_global_dbg_en,
  input  wire logic                      i_tx_wr,
  input  wire logic [31:0]               i_tx_data,
  output logic                           o_tx_ready,
  input  wire logic                      i_scratch_wr,
  input  wire logic                      i_scratch_op_ok,
  input  wire logic [31:0]               i_scratch_wdata,
  output logic [31:0]                    o_scratch_rdata,
  input  wire logic                      i_fetch_req,
  input  wire logic [31:0]               i_fetch_addr,
  output logic                           o_fetch_hit,
  output logic [31:0]                    o_fetch_data,
  output logic                           o_ifetch_xlate_en,
  output logic                           o_dacc_xlate_en,
  input  wire logic [halt_dbg_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [31:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic [31:0]                    o_rdata,
  output logic                           o_irq
);
  import halt_dbg_pkg::*;

  typedef struct packed {
    mode_e                       mode;
    logic [31:0]                 debug_control_status_reg;
    logic                        tx_ready;
    logic [31:0]                 tx_data;
    logic [31:0]                 scratch;
    logic                        exc;
    logic [31:0]                 vec;
    logic                        tck_q;
    logic                        tsel_q;
    logic [FRAME_BITS-1:0]       sr;
    logic [5:0]                  nbits;
    logic                        cap_ready;
    logic [SETS-1:0]             rr;
    logic [LINES-1:0]            valid;
    logic [LINES-1:0][TAG_W-1:0] tag;
    logic                        ld_act;
    logic [4:0]                  ld_set;
    logic                        ld_way;
    logic [2:0]                  ld_word;
    logic [EV_W-1:0]             status;
    logic [EV_W-1:0]             enable;
    logic [31:0]                 rdata;
    logic                        hit;
  } state_s;

  state_s            s_r;
  state_s            s_nxt;
  logic [2:0]        pins;
  logic              tck_s;
  logic              tsel_s;
  logic              tdi_s;
  logic              tck_rise;
  logic              frame_end;
  logic [OP_W-1:0]   op;
  logic [31:0]       fdata;
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   clr;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [MEM_AW-1:0] mem_ra;
  logic [4:0]        f_set;
  logic              h0;
  logic              h1;
  logic              rr_sel;

  sync2 #(.W(3)) u_sync (
    .i_clk (i_clk),
    .i_d   ({i_tck, i_tsel, i_tdi}),
    .o_q   (pins)
  );

  mini_icache_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_wa),
    .i_wdata (fdata),
    .i_raddr (mem_ra),
    .o_rdata (o_fetch_data)
  );

  assign tck_s     = pins[2];
  assign tsel_s    = pins[1];
  assign tdi_s     = pins[0];
  assign tck_rise  = tck_s & ~s_r.tck_q;
  assign frame_end = ~tsel_s & s_r.tsel_q & (s_r.nbits == FRAME_LEN);
  assign op        = s_r.sr[OP_W-1:0];
  assign fdata     = s_r.sr[FRAME_BITS-1:OP_W];
  assign rr_sel    = s_r.rr[s_r.ld_set];
  assign f_set     = set_of(i_fetch_addr);
  assign h0 = s_r.valid[line_of(f_set, 1'b0)] && s_r.tag[line_of(f_set, 1'b0)] == tag_of(i_fetch_addr);
  assign h1 = s_r.valid[line_of(f_set, 1'b1)] && s_r.tag[line_of(f_set, 1'b1)] == tag_of(i_fetch_addr);
  assign mem_ra    = {f_set, h1, i_fetch_addr[WORD_LSB+2:WORD_LSB]};
  assign clr       = (i_wr && i_addr == REG_CLEAR) ? i_wdata[EV_W-1:0] : '0;

  always_comb begin
    s_nxt        = s_r;
    ev           = '0;
    mem_we       = 1'b0;
    mem_wa       = {s_r.ld_set, s_r.ld_way, s_r.ld_word};
    s_nxt.exc    = 1'b0;
    s_nxt.tck_q  = tck_s;
    s_nxt.tsel_q = tsel_s;
    // R17 scan register captures ready flag at frame start
    if (tsel_s && !s_r.tsel_q) begin
      s_nxt.sr        = {3'h0, s_r.tx_data, s_r.tx_ready};
      s_nxt.nbits     = '0;
      s_nxt.cap_ready = s_r.tx_ready;
    end else if (tsel_s && tck_rise) begin
      s_nxt.sr = {tdi_s, s_r.sr[FRAME_BITS-1:1]};
      if (s_r.nbits != FRAME_LEN) begin
        s_nxt.nbits = s_r.nbits + 6'h1;
      end
    end
    if (frame_end) begin
      case (op)
        OP_POLL: begin
          // R19 host read clears ready flag
          if (s_r.cap_ready) begin
            s_nxt.tx_ready = 1'b0;
            ev[EV_HOST_RD] = 1'b1;
          end
        end
        OP_WR_CSR: begin
          s_nxt.debug_control_status_reg = fdata;
        end
        OP_LINE: begin
          // R14 way taken from round-robin pointer
          s_nxt.ld_act  = 1'b1;
          s_nxt.ld_set  = set_of(fdata);
          s_nxt.ld_way  = s_r.rr[set_of(fdata)];
          s_nxt.ld_word = '0;
          s_nxt.valid[line_of(set_of(fdata), s_r.rr[set_of(fdata)])] = 1'b0;
          s_nxt.tag[line_of(set_of(fdata), s_r.rr[set_of(fdata)])]   = tag_of(fdata);
          // R06 flag download to a line address whose low 12 bits are zero
          if (fdata[11:0] == 12'h000) begin
            ev[EV_CLASH] = 1'b1;
          end
        end
        OP_WORD: begin
          if (s_r.ld_act) begin
            mem_we        = 1'b1;
            s_nxt.ld_word = s_r.ld_word + 3'h1;
            // R18 line complete: validate and advance pointer
            if (s_r.ld_word == LAST_WORD) begin
              s_nxt.ld_act                           = 1'b0;
              s_nxt.valid[line_of(s_r.ld_set, s_r.ld_way)] = 1'b1;
              s_nxt.rr[s_r.ld_set]                   = ~s_r.rr[s_r.ld_set];
            end
          end
        end
        OP_INV_ALL: begin
          s_nxt.valid  = '0;
          s_nxt.ld_act = 1'b0;
        end
        OP_INV_LINE: begin
          for (int w = 0; w < WAYS; w++) begin
            if (s_r.tag[line_of(set_of(fdata), w[0])] == tag_of(fdata)) begin
              s_nxt.valid[line_of(set_of(fdata), w[0])] = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // R08 handler write sets ready; set wins over host clear
    if (i_tx_wr) begin
      s_nxt.tx_ready  = 1'b1;
      s_nxt.tx_data   = i_tx_data;
      s_nxt.cap_ready = 1'b0;
      ev[EV_TX_WR]    = 1'b1;
    end
    unique case (s_r.mode)
      md_reset: begin
        if (!i_core_in_reset) begin
          s_nxt.mode = md_run;
          // R02 reset vector trap on release
          if (s_r.debug_control_status_reg[CSR_TRAP_BIT]) begin
            s_nxt.mode = md_debug;
            s_nxt.exc  = 1'b1;
          end
        end
      end
      md_run: begin
        if (i_core_in_reset) begin
          s_nxt.mode = md_reset;
        // R03 other exceptions need global enable
        end else if (i_dbg_event && s_r.debug_control_status_reg[CSR_GE_BIT]) begin
          s_nxt.mode = md_debug;
          s_nxt.exc  = 1'b1;
        end
      end
      md_debug: begin
        if (i_core_in_reset) begin
          s_nxt.mode = md_reset;
        end else if (i_handler_exit) begin
          s_nxt.mode = md_run;
        end
      end
    endcase
    // R10 scratch only by permitted ops, lost on exception
    if (i_scratch_wr && i_scratch_op_ok && s_r.mode == md_debug) begin
      s_nxt.scratch = i_scratch_wdata;
    end
    if (s_nxt.exc) begin
      // R05 relocated vector selects the high address
      s_nxt.vec      = i_vec_relocated ? VEC_HIGH : VEC_LOW;
      s_nxt.scratch  = '0;
      ev[EV_ENTRY]   = 1'b1;
    end
    // R15 misses never allocate; only downloads fill lines
    s_nxt.hit    = i_fetch_req & (h0 | h1);
    s_nxt.status = (s_r.status & ~clr) | ev;
    if (i_wr && i_addr == REG_ENABLE) begin
      s_nxt.enable = i_wdata[EV_W-1:0];
    end
    s_nxt.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        REG_STATUS: s_nxt.rdata = {28'h0, s_r.status};
        REG_ENABLE: s_nxt.rdata = {28'h0, s_r.enable};
        REG_CSR:    s_nxt.rdata = s_r.debug_control_status_reg;
        default:    s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s_r        <= '0;
      s_r.debug_control_status_reg <= CSR_RST;
      s_r.status <= EV_RST;
      s_r.enable <= EV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_tdo           = s_r.sr[0];
  assign o_debug_exc     = s_r.exc;
  assign o_debug_vector  = s_r.vec;
  assign o_debug_mode    = s_r.mode == md_debug;
  assign o_global_dbg_en = s_r.debug_control_status_reg[CSR_GE_BIT];
  assign o_tx_ready      = s_r.tx_ready;
  assign o_scratch_rdata = s_r.scratch;
  assign o_fetch_hit     = s_r.hit;
  // R09 fetch translation off in debug mode, data unaffected
  assign o_ifetch_xlate_en = s_r.mode != md_debug;
  assign o_dacc_xlate_en   = 1'b1;
  assign o_rdata         = s_r.rdata;
  assign o_irq           = |(s_r.status & s_r.enable);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_reset_trap: assert property ( // R02
    s_r.mode == md_reset && !i_core_in_reset && s_r.debug_control_status_reg[CSR_TRAP_BIT]
    |=> o_debug_exc && o_debug_mode) else $error("reset trap not taken");
  a_gated_exc: assert property ( // R03
    s_r.mode == md_run && i_dbg_event && !s_r.debug_control_status_reg[CSR_GE_BIT]
    |=> !o_debug_exc) else $error("exception taken with debug disabled");
  a_vector_sel: assert property (o_debug_exc // R05
    |-> o_debug_vector == ($past(i_vec_relocated) ? VEC_HIGH : VEC_LOW)) else $error("wrong vector");
  a_clash_flag: assert property (frame_end && op == OP_LINE && fdata[11:0] == 12'h000 // R06
    |=> s_r.status[EV_CLASH]) else $error("set 0 download not flagged");
  a_tx_ready_set: assert property (i_tx_wr |=> o_tx_ready ##0 s_r.tx_data == $past(i_tx_data)) // R08
    else $error("tx write did not set ready");
  a_scan_capture: assert property ($rose(s_r.tsel_q) |-> s_r.sr[0] == $past(s_r.tx_ready)) // R17
    else $error("scan bit 0 not ready flag");
  a_fetch_xlate: assert property (o_debug_mode |-> !o_ifetch_xlate_en && o_dacc_xlate_en) // R09
    else $error("fetch translation active in debug");
  a_scratch_lost: assert property (o_debug_exc |-> o_scratch_rdata == 32'h0) // R10
    else $error("scratch survived exception");
  a_rr_way: assert property (frame_end && op == OP_LINE // R14
    |=> s_r.ld_act && s_r.ld_set == set_of($past(fdata)) && s_r.ld_way == rr_sel)
    else $error("way not round robin");
  a_no_fill: assert property (!frame_end |=> (s_r.valid & ~$past(s_r.valid)) == '0) // R15
    else $error("line filled outside download");
  a_rr_advance: assert property (frame_end && op == OP_WORD && s_r.ld_act && s_r.ld_word == LAST_WORD // R18
    |=> s_r.rr[$past(s_r.ld_set)] != $past(rr_sel)) else $error("pointer not advanced");
  a_ready_clear: assert property (frame_end && op == OP_POLL && s_r.cap_ready && !i_tx_wr // R19
    |=> !o_tx_ready ##0 s_r.status[EV_HOST_RD]) else $error("ready not cleared");
  a_irq_level: assert property (i_tx_wr && s_r.enable[EV_TX_WR] && !(i_wr && i_addr == REG_ENABLE) // R08
    |=> o_irq) else $error("irq low after enabled event");

  c_trap_entry: cover property (s_r.mode == md_reset ##1 o_debug_exc);
  c_line_done:  cover property (frame_end && op == OP_WORD && s_r.ld_word == LAST_WORD);
  c_poll_clear: cover property (o_tx_ready ##[1:1000] !o_tx_ready);
  c_fetch_hit:  cover property (o_fetch_hit && o_debug_mode);
endmodule : halt_mode_debug_entry

/* File: dv/jtag_host_model.sv */
// debugger host model: sends scan frames and collects the bits shifted out
`timescale 1ns/1ps
module jtag_host_model (
  output logic      o_tck,
  output logic      o_tsel,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial begin
    o_tck  = 1'b0;
    o_tsel = 1'b0;
    o_tdi  = 1'b1;
  end
  // test clock runs only inside a frame; select moves while it is low
  task automatic frame(input int nbits, input logic [35:0] din, output logic [35:0] dout);
    dout   = '0;
    o_tsel = 1'b1;
    #160;
    for (int i = 0; i < nbits; i++) begin
      o_tdi = din[i];
      #80;
      dout[i] = i_tdo;
      o_tck   = 1'b1;
      #80;
      o_tck   = 1'b0;
    end
    #40;
    o_tsel = 1'b0;
    // released data line shows the inverse of its last bit
    o_tdi  = ~o_tdi;
    #400;
  endtask : frame
endmodule : jtag_host_model

/* File: dv/halt_mode_debug_entry_test.sv */
// self-checking bench for the halt mode debug entry block
`timescale 1ns/1ps
module halt_mode_debug_entry_test;
  import halt_dbg_pkg::*;
  // handler start well inside branch reach
  localparam logic [31:0] HND = 32'h0000_0100;
  localparam logic [31:0] A1  = 32'h0000_10a0;
  localparam logic [31:0] A2  = 32'h0000_20a0;
  localparam logic [31:0] A3  = 32'h0000_30a0;
  logic        clk, srst, core_rst, reloc, dbg_ev, h_exit, tx_wr, scr_wr, scr_ok, f_req, wr, rd;
  logic [31:0] tx_data, scr_wd, f_addr, wdata, vec, scr_rd, f_data, rdata;
  logic [3:0]  addr;
  wire         tck, tsel, tdi;
  logic        tdo, exc, dmode, ge, txr, f_hit, ix, dx, irq;
  int          err_count = 0;
  int          n_checks = 0;

  halt_mode_debug_entry i_halt_mode_debug_entry (
    .i_clk(clk), .i_srst(srst), .i_tck(tck), .i_tsel(tsel), .i_tdi(tdi), .o_tdo(tdo),
    .i_core_in_reset(core_rst), .i_vec_relocated(reloc), .i_dbg_event(dbg_ev), .i_handler_exit(h_exit),
    .o_debug_exc(exc), .o_debug_vector(vec), .o_debug_mode(dmode), .o_global_dbg_en(ge),
    .i_tx_wr(tx_wr), .i_tx_data(tx_data), .o_tx_ready(txr), .i_scratch_wr(scr_wr), .i_scratch_op_ok(scr_ok),
    .i_scratch_wdata(scr_wd), .o_scratch_rdata(scr_rd), .i_fetch_req(f_req), .i_fetch_addr(f_addr),
    .o_fetch_hit(f_hit), .o_fetch_data(f_data), .o_ifetch_xlate_en(ix), .o_dacc_xlate_en(dx),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq)
  );
  jtag_host_model i_jtag_host_model (.o_tck(tck), .o_tsel(tsel), .o_tdi(tdi), .i_tdo(tdo));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic fetch(input logic [31:0] a, output logic h, output logic [31:0] d);
    @(posedge clk);
    f_addr <= a;
    f_req  <= 1'b1;
    @(posedge clk);
    f_req  <= 1'b0;
    #1;
    h = f_hit;
    d = f_data;
  endtask : fetch

  task automatic scan(input logic [3:0] op, input logic [31:0] d, output logic [35:0] q);
    i_jtag_host_model.frame(36, {d, op}, q);
  endtask : scan

  task automatic dl_line(input logic [31:0] a, input logic [31:0] b);
    logic [35:0] q;
    scan(OP_LINE, a, q);
    for (int k = 0; k < WORDS; k++) begin
      scan(OP_WORD, b + 32'(k), q);
    end
  endtask : dl_line

  task automatic wait_exc(input string what);
    int n;
    n = 0;
    while (exc !== 1'b1) begin
      if (n == 8) begin
        check(what, 1'b0, 1'b1);
        results();
      end
      cyc(1);
      n++;
    end
  endtask : wait_exc

  task automatic no_exc(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      cyc(1);
      seen = seen | exc;
    end
  endtask : no_exc

  task automatic pulse_exit();
    @(posedge clk);
    h_exit <= 1'b1;
    @(posedge clk);
    h_exit <= 1'b0;
    cyc(1);
  endtask : pulse_exit

  task automatic t_trap();
    logic [35:0] q;
    logic [31:0] d;
    logic        h;
    check("xlate at reset", {ix, dx, ge, dmode}, 4'hc);
    // tables and handler loaded while the core is held in reset
    dl_line(VEC_LOW, 32'hd000_0000);
    dl_line(VEC_HIGH, 32'hd100_0000);
    // handler kept clear of set 0
    dl_line(HND, 32'hd200_0000);
    reg_rd(REG_STATUS, d);
    check("clash event", d[EV_CLASH], 1'b1);
    fetch(HND + 32'h8, h, d);
    check("handler hit", h, 1'b1);
    check("handler word", d, 32'hd200_0002);
    scan(OP_WR_CSR, 32'h0001_0000, q);
    reg_rd(REG_CSR, d);
    check("csr trap", d, 32'h0001_0000);
    check("exc in reset", exc, 1'b0);
    @(posedge clk);
    core_rst <= 1'b0;
    cyc(1);
    wait_exc("reset trap");
    check("low vector", vec, VEC_LOW);
    check("mode and xlate", {dmode, ix, dx}, 3'h5);
    cyc(1);
    check("exc pulse", exc, 1'b0);
    reg_rd(REG_STATUS, d);
    check("entry event", d[EV_ENTRY], 1'b1);
    $display("test reset trap done");
  endtask : t_trap

  task automatic t_mode();
    logic [35:0] q;
    logic [31:0] d;
    logic        s;
    logic        h;
    @(posedge clk);
    scr_wd <= 32'h1234_5678;
    scr_wr <= 1'b1;
    @(posedge clk);
    scr_ok <= 1'b1;
    #1;
    check("scratch refused", scr_rd, 32'h0);
    @(posedge clk);
    scr_wr <= 1'b0;
    cyc(1);
    check("scratch", scr_rd, 32'h1234_5678);
    fetch(HND, h, d);
    check("debug fetch hit", h, 1'b1);
    check("debug fetch word", d, 32'hd200_0000);
    pulse_exit();
    check("left debug", {dmode, ix}, 2'h1);
    @(posedge clk);
    dbg_ev <= 1'b1;
    no_exc(6, s);
    check("event gated", s, 1'b0);
    @(posedge clk);
    dbg_ev <= 1'b0;
    // global enable set by the debugger
    scan(OP_WR_CSR, 32'h8001_0000, q);
    check("global enable", ge, 1'b1);
    @(posedge clk);
    reloc  <= 1'b1;
    dbg_ev <= 1'b1;
    wait_exc("enabled event");
    check("high vector", vec, VEC_HIGH);
    check("scratch lost", scr_rd, 32'h0);
    no_exc(6, s);
    check("event in debug", s, 1'b0);
    @(posedge clk);
    dbg_ev <= 1'b0;
    pulse_exit();
    $display("test debug entry done");
  endtask : t_mode

  task automatic t_tx();
    logic [35:0] q;
    logic [31:0] d;
    reg_wr(REG_CLEAR, 32'hf);
    reg_wr(REG_ENABLE, 32'h1);
    @(posedge clk);
    tx_wr   <= 1'b1;
    tx_data <= 32'h5a5a_1234;
    @(posedge clk);
    tx_wr   <= 1'b0;
    cyc(1);
    check("ready and irq", {txr, irq}, 2'h3);
    reg_wr(REG_STATUS, 32'h0);
    reg_rd(REG_STATUS, d);
    check("status tx", d, 32'h1);
    scan(OP_POLL, 32'h0, q);
    check("scan data", q[32:1], 32'h5a5a_1234);
    check("scan ready", {q[35:33], q[0]}, 4'h1);
    check("ready cleared", txr, 1'b0);
    reg_rd(REG_STATUS, d);
    check("host read event", d[EV_HOST_RD], 1'b1);
    scan(OP_POLL, 32'h0, q);
    check("second poll", q[0], 1'b0);
    reg_wr(REG_ENABLE, 32'h0);
    check("irq masked", irq, 1'b0);
    reg_wr(REG_CLEAR, 32'hf);
    reg_rd(REG_STATUS, d);
    check("status cleared", d, 32'h0);
    i_jtag_host_model.frame(35, {32'h0, OP_WR_CSR}, q);
    reg_wr(REG_CSR, 32'h0);
    reg_rd(REG_CSR, d);
    check("csr kept", d, 32'h8001_0000);
    reg_rd(4'h2, d);
    check("unmapped", d, 32'h0);
    $display("test transmit handshake done");
  endtask : t_tx

  task automatic t_cache();
    logic [35:0] q;
    logic [31:0] d;
    logic        h;
    // set 5 is kept for dynamic downloads only
    dl_line(A1, 32'ha100_0000);
    dl_line(A2, 32'ha200_0000);
    fetch(A1, h, d);
    check("first way", h, 1'b1);
    fetch(A2 + 32'h4, h, d);
    check("second way", d, 32'ha200_0001);
    dl_line(A3, 32'ha300_0000);
    fetch(A1, h, d);
    check("replaced", h, 1'b0);
    fetch(A3 + 32'h1c, h, d);
    check("new line hit", h, 1'b1);
    check("new line word", d, 32'ha300_0007);
    fetch(32'h0000_50a0, h, d);
    fetch(32'h0000_50a0, h, d);
    check("no app fill", h, 1'b0);
    fetch(A2, h, d);
    check("kept line", h, 1'b1);
    scan(OP_INV_LINE, A2, q);
    fetch(A2, h, d);
    check("line invalid", h, 1'b0);
    scan(OP_INV_ALL, 32'h0, q);
    fetch(A3, h, d);
    check("all invalid", h, 1'b0);
    $display("test mini cache done");
  endtask : t_cache

  initial begin
    srst     = 1'b1;
    core_rst = 1'b1;
    {reloc, dbg_ev, h_exit, tx_wr, scr_wr, scr_ok, f_req, wr, rd} = '0;
    {tx_data, scr_wd, f_addr, wdata} = '0;
    addr     = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    cyc(1);
    t_trap();
    t_mode();
    t_tx();
    t_cache();
    results();
  end
endmodule : halt_mode_debug_entry_test
